// File: rtl/sadc_control.sv
// control logic of the 8-bit serial successive-approximation converter
// Notes on behaviour
// - serial clock, chip select, address in; one three-state data out.
// - twelve-way mux: eleven analog inputs or internal self-test voltage.
// - eight-bit result built by successive approximation.
// - sampling starts only when the host commands it over the port.
// - every conversion finishes within 20 us of its start.
// - end-of-conversion goes high when the result is ready.
// - after select falls, wait two rises and one fall of system clock.
// - data output floats whenever chip select is high.
// - data output floats at the falling edge of the eighth clock.
// - over-range reads all ones, under-range reads all zeros.
// - address bits are captured on rising serial clock edges.
`timescale 1ns/1ps
`default_nettype none
module sadc_control #(
	parameter int BIT_CYCLES = sadc_pkg::BIT_CYCLES_DEF,
	parameter int SYSCLK_HALF = sadc_pkg::SYSCLK_HALF_DEF
) (
	input wire logic clock, // 20 MHz block clock
	input wire logic arst_n, // asynchronous reset, active low
	input wire sadc_pkg::sadc_host_t host_pins, // raw host pins
	input wire logic cmp_high, // comparator: input at or above dac level
	output logic data_out, // serial result bit
	output logic data_oe, // high while data_out is driven
	output logic eoc, // end of conversion
	output logic [sadc_pkg::ADDR_W-1:0] mux_sel, // analog mux position
	output logic sample, // sample-and-hold tracking
	output logic [sadc_pkg::RESULT_W-1:0] dac_code // trial code to the comparator
);
	localparam int CONV_LIM = sadc_pkg::CONV_MAX_CYCLES;

	// two-flop synchronisers; only the second stage and later are read
	logic [3:0] sync1;
	logic [3:0] sync2;
	logic io_prev;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sync1 <= 4'h9;
			sync2 <= 4'h9;
			io_prev <= 1'b0;
		end else begin
			sync1 <= {host_pins.cs_n, host_pins.io_clk, host_pins.addr, cmp_high};
			sync2 <= sync1;
			io_prev <= sync2[2];
		end
	end
	logic cs_s;
	logic io_s;
	logic addr_s;
	logic cmp_s;
	assign cs_s = sync2[3];
	assign io_s = sync2[2];
	assign addr_s = sync2[1];
	assign cmp_s = sync2[0];
	logic io_rise;
	logic io_fall;
	assign io_rise = io_s && !io_prev;
	assign io_fall = !io_s && io_prev;

	// free-running internal system clock
	logic [7:0] sys_div;
	logic sys_clk;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sys_div <= 8'h00;
			sys_clk <= 1'b0;
		end else if (sys_div == 8'(SYSCLK_HALF - 1)) begin
			sys_div <= 8'h00;
			sys_clk <= !sys_clk;
		end else begin
			sys_div <= sys_div + 8'h01;
		end
	end
	logic sys_rise;
	logic sys_fall;
	assign sys_rise = (sys_div == 8'(SYSCLK_HALF - 1)) && !sys_clk;
	assign sys_fall = (sys_div == 8'(SYSCLK_HALF - 1)) && sys_clk;

	sadc_pkg::sadc_state_t state;
	logic [1:0] filt_rises;
	logic filt_fall;
	logic filt_ok;
	assign filt_ok = (filt_rises == sadc_pkg::FILTER_RISES) && filt_fall;

	// select filter: glitches shorter than the wait never open the port
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			filt_rises <= 2'h0;
			filt_fall <= 1'b0;
		end else if (state != sadc_pkg::ST_ARM) begin
			filt_rises <= 2'h0;
			filt_fall <= 1'b0;
		end else begin
			if (sys_rise && filt_rises != sadc_pkg::FILTER_RISES)
				filt_rises <= filt_rises + 2'h1;
			if (sys_fall && filt_rises != 2'h0)
				filt_fall <= 1'b1;
		end
	end

	logic [sadc_pkg::CNT_W-1:0] rise_cnt;
	logic [sadc_pkg::CNT_W-1:0] fall_cnt;
	logic last_fall;
	logic conv_start;
	assign last_fall = (state == sadc_pkg::ST_SHIFT) && io_fall
		&& (fall_cnt == sadc_pkg::CNT_W'(sadc_pkg::XFER_CLKS - 1));
	assign conv_start = last_fall;

	// transfer sequencer; a new transfer needs select to go high again
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state <= sadc_pkg::ST_IDLE;
		end else if (cs_s) begin
			state <= sadc_pkg::ST_IDLE;
		end else begin
			case (state)
				sadc_pkg::ST_IDLE: state <= sadc_pkg::ST_ARM;
				sadc_pkg::ST_ARM: if (filt_ok) state <= sadc_pkg::ST_SHIFT;
				sadc_pkg::ST_SHIFT: if (last_fall) state <= sadc_pkg::ST_DONE;
				default: state <= sadc_pkg::ST_DONE;
			endcase
		end
	end

	logic [sadc_pkg::RESULT_W-1:0] result;
	logic [sadc_pkg::RESULT_W-1:0] out_sr;
	logic [sadc_pkg::ADDR_W-1:0] addr_sr;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rise_cnt <= '0;
			fall_cnt <= '0;
			out_sr <= sadc_pkg::RESULT_RST;
			addr_sr <= '0;
		end else if (state != sadc_pkg::ST_SHIFT) begin
			rise_cnt <= '0;
			fall_cnt <= '0;
			out_sr <= result;
		end else begin
			if (io_rise && rise_cnt < sadc_pkg::CNT_W'(sadc_pkg::ADDR_CLKS)) begin
				addr_sr <= {addr_sr[sadc_pkg::ADDR_W-2:0], addr_s};
				rise_cnt <= rise_cnt + 1'b1;
			end
			if (io_fall) begin
				out_sr <= {out_sr[sadc_pkg::RESULT_W-2:0], 1'b0};
				fall_cnt <= fall_cnt + 1'b1;
			end
		end
	end
	assign data_out = out_sr[sadc_pkg::RESULT_W-1];
	assign data_oe = (state == sadc_pkg::ST_SHIFT) && !cs_s;

	// channel select; codes past the last input fall to the self-test source
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			mux_sel <= sadc_pkg::SELFTEST_CH;
		else if (state == sadc_pkg::ST_SHIFT && rise_cnt == sadc_pkg::CNT_W'(sadc_pkg::ADDR_CLKS))
			mux_sel <= (addr_sr > sadc_pkg::SELFTEST_CH) ? sadc_pkg::SELFTEST_CH : addr_sr;
	end
	// tracking runs from the fourth address clock to the eighth falling edge
	assign sample = (state == sadc_pkg::ST_SHIFT)
		&& (rise_cnt == sadc_pkg::CNT_W'(sadc_pkg::ADDR_CLKS));

	// successive approximation; an input beyond either reference keeps or
	// drops every trial bit, giving all ones or all zeros
	logic conv_busy;
	logic [sadc_pkg::RESULT_W-1:0] trial;
	logic [7:0] step;
	logic step_end;
	logic conv_done;
	assign step_end = conv_busy && (step == 8'(BIT_CYCLES - 1));
	assign conv_done = step_end && trial[0];
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			conv_busy <= 1'b0;
			trial <= '0;
			step <= 8'h00;
			dac_code <= sadc_pkg::RESULT_RST;
		end else if (conv_start) begin
			conv_busy <= 1'b1;
			trial <= sadc_pkg::SAR_FIRST;
			step <= 8'h00;
			dac_code <= sadc_pkg::SAR_FIRST;
		end else if (step_end) begin
			step <= 8'h00;
			trial <= trial >> 1;
			dac_code <= (cmp_s ? dac_code : (dac_code & ~trial)) | (trial >> 1);
			if (trial[0])
				conv_busy <= 1'b0;
		end else if (conv_busy) begin
			step <= step + 8'h01;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			result <= sadc_pkg::RESULT_RST;
			eoc <= 1'b1;
		end else if (conv_start) begin
			eoc <= 1'b0;
		end else if (conv_done) begin
			result <= cmp_s ? dac_code : (dac_code & ~trial);
			eoc <= 1'b1;
		end
	end

	// helper: age of the running conversion
	logic [15:0] conv_age;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			conv_age <= 16'h0000;
		else if (!conv_busy)
			conv_age <= 16'h0000;
		else
			conv_age <= conv_age + 16'h0001;
	end

	conv_bound_a: assert property (@(posedge clock) disable iff (!arst_n)
		conv_busy |-> conv_age < 16'(CONV_LIM))
		else $error("conversion exceeds its time limit");
	eoc_fall_a: assert property (@(posedge clock) disable iff (!arst_n)
		conv_start |=> !eoc && conv_busy)
		else $error("eoc not low after conversion start");
	eoc_low_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
		conv_busy |=> !eoc || $past(conv_done))
		else $error("eoc rose before result stored");
	eoc_rise_a: assert property (@(posedge clock) disable iff (!arst_n)
		conv_done && !conv_start |=> eoc && !conv_busy)
		else $error("eoc not high after conversion");
	// the raw pin is watched so the synchroniser path is covered, not just the gate
	oe_select_a: assert property (@(posedge clock) disable iff (!arst_n)
		host_pins.cs_n |-> ##2 !data_oe)
		else $error("data driven while select high");
	oe_eighth_a: assert property (@(posedge clock) disable iff (!arst_n)
		last_fall |=> !data_oe [*3])
		else $error("data still driven after eighth clock");
	select_filter_a: assert property (@(posedge clock) disable iff (!arst_n)
		$rose(data_oe) |-> $past(filt_ok))
		else $error("port opened before select filter ran");
	mux_range_a: assert property (@(posedge clock) disable iff (!arst_n)
		$changed(mux_sel) |-> mux_sel <= sadc_pkg::SELFTEST_CH
			&& $past(state) == sadc_pkg::ST_SHIFT)
		else $error("mux position out of range or unsolicited");
	first_bit_a: assert property (@(posedge clock) disable iff (!arst_n)
		$rose(data_oe) |-> data_out == $past(result[sadc_pkg::RESULT_W-1]))
		else $error("first bit is not result msb");
	start_cmd_a: assert property (@(posedge clock) disable iff (!arst_n)
		$rose(conv_busy) |-> $past(io_fall) && $past(state == sadc_pkg::ST_SHIFT))
		else $error("conversion started without host command");
endmodule : sadc_control
`default_nettype wire

// File: shared/sadc_pkg.sv
// shared constants and carrier types for the serial converter control block
package sadc_pkg;
	localparam int RESULT_W = 8;
	localparam int ADDR_W = 4;
	localparam int XFER_CLKS = 8;
	localparam int ADDR_CLKS = 4;
	localparam int CNT_W = 4;
	localparam logic [ADDR_W-1:0] SELFTEST_CH = 4'hb;
	localparam logic [RESULT_W-1:0] SAR_FIRST = 8'h80;
	localparam logic [RESULT_W-1:0] RESULT_RST = 8'h00;
	localparam logic [1:0] FILTER_RISES = 2'h2;
	localparam int CLK_MHZ = 20;
	localparam int CONV_TIME_NS = 20000;
	localparam int CONV_MAX_CYCLES = CONV_TIME_NS * CLK_MHZ / 1000;
	localparam int BIT_CYCLES_DEF = 16;
	localparam int SYSCLK_HALF_DEF = 4;

	typedef struct packed {
		logic cs_n;
		logic io_clk;
		logic addr;
	} sadc_host_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_ARM = 4'h2,
		ST_SHIFT = 4'h4,
		ST_DONE = 4'h8
	} sadc_state_t;
endpackage : sadc_pkg

// File: testbench/sadc_host_model.sv
// host side of the three-wire serial port
`timescale 1ns/1ps
`default_nettype none
module sadc_host_model (
	input wire logic clock, // block clock, paces the host
	input wire logic data_out, // serial result bit
	input wire logic data_oe, // result line driven
	output var sadc_pkg::sadc_host_t pins // host pins
);
	initial pins = '{cs_n: 1'b1, io_clk: 1'b0, addr: 1'b0};
	// io clock runs only inside a frame: 4 cycles high, 4 low, 400 ns period
	task automatic xfer(input logic [3:0] ch, input int bits, output logic [7:0] rd,
		output logic early, output logic oe_all);
		rd = 8'h00;
		oe_all = 1'b1;
		@(posedge clock);
		pins.cs_n <= 1'b0;
		repeat (5) @(posedge clock);
		@(negedge clock);
		early = data_oe;
		repeat (20) @(posedge clock);
		for (int k = 0; k < bits; k++) begin
			// unused address slots carry a toggling level, not a held one
			pins.addr <= (k < 4) ? ch[3 - k] : ~pins.addr;
			repeat (4) @(posedge clock);
			pins.io_clk <= 1'b1;
			repeat (3) @(posedge clock);
			@(negedge clock);
			// a released line reads as the inverse, so a read while floating fails
			rd = {rd[6:0], data_oe ? data_out : ~data_out};
			oe_all = oe_all & data_oe;
			@(posedge clock);
			pins.io_clk <= 1'b0;
		end
	endtask : xfer
	task automatic deselect;
		@(posedge clock);
		pins.cs_n <= 1'b1;
		pins.addr <= ~pins.addr;
		repeat (4) @(posedge clock);
	endtask : deselect
endmodule : sadc_host_model
`default_nettype wire

// File: testbench/test_serial_adc_control.sv
// self-checking bench for the serial converter control block
`timescale 1ns/1ps
`default_nettype none
module test_serial_adc_control;
	logic clock, arst_n, cmp_high, data_out, data_oe, eoc, sample, early, oe_all;
	logic [sadc_pkg::ADDR_W-1:0] mux_sel;
	logic [7:0] dac_code, rd;
	sadc_pkg::sadc_host_t host_pins;
	int level [12] = '{32'h12c, -32'h5, 0, 32'ha5, 0, 0, 0, 32'h5a, 0, 0, 32'h1, 32'h80};
	int mismatches = 0;
	int checks = 0;
	int smp_cycles = 0;
	sadc_control #(.BIT_CYCLES(8), .SYSCLK_HALF(2)) sadc_control_i (.clock(clock),
		.arst_n(arst_n), .host_pins(host_pins), .cmp_high(cmp_high), .data_out(data_out),
		.data_oe(data_oe), .eoc(eoc), .mux_sel(mux_sel), .sample(sample), .dac_code(dac_code));
	sadc_host_model sadc_host_model_i (.clock(clock), .data_out(data_out), .data_oe(data_oe),
		.pins(host_pins));
	// analog side: levels beyond the range saturate, so the code pins at ff or 00
	always @(posedge clock) cmp_high <= level[mux_sel] >= int'(dac_code);
	// tracking time on the sample output; tests read it as differences
	always @(negedge clock) if (sample === 1'b1) smp_cycles++;
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		checks++;
		if (seen !== want) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check
	task automatic complete_run;
		$display("counts: %0d checks, %0d mismatches", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : complete_run
	// a whole transfer hands back the result stored before it
	task automatic convert(input logic [3:0] ch, input logic [7:0] prev);
		int n;
		int s0;
		n = 0;
		s0 = smp_cycles;
		sadc_host_model_i.xfer(ch, 8, rd, early, oe_all);
		repeat (6) @(negedge clock);
		check(8'(early), 8'h00);
		check(8'({oe_all, data_oe, eoc, sample}), 8'h08);
		// tracking spans four and a half io periods of eight clocks each
		check(8'(smp_cycles - s0), 8'h24);
		check(rd, prev);
		check(8'(mux_sel), (ch > 4'hb) ? 8'h0b : 8'(ch));
		while (eoc !== 1'b1 && n < 500) begin
			@(negedge clock);
			n++;
		end
		check(8'(n < 394), 8'h01);
		sadc_host_model_i.deselect();
		$display("transfer on channel %h done", ch);
	endtask : convert
	task automatic abort_xfer;
		int lows;
		int s0;
		lows = 0;
		s0 = smp_cycles;
		sadc_host_model_i.xfer(4'h7, 3, rd, early, oe_all);
		sadc_host_model_i.deselect();
		@(negedge clock);
		check(8'({data_oe, eoc, sample}), 8'h02);
		// any started conversion would pull eoc low somewhere in this span
		repeat (100) begin
			@(negedge clock);
			if (eoc !== 1'b1) lows++;
		end
		check(8'(lows), 8'h00);
		check(8'(smp_cycles - s0), 8'h00);
		$display("aborted transfer done");
	endtask : abort_xfer
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	initial begin
		logic [3:0] chs [7] = '{4'h3, 4'h0, 4'h1, 4'h7, 4'ha, 4'hd, 4'h3};
		logic [7:0] prevs [7] = '{8'h00, 8'ha5, 8'hff, 8'h00, 8'h5a, 8'h01, 8'h80};
		arst_n = 1'b0;
		repeat (12) @(posedge clock);
		arst_n <= 1'b1;
		repeat (50) @(negedge clock);
		check(8'({data_oe, eoc, sample}), 8'h02);
		check(8'(mux_sel), 8'h0b);
		$display("reset test done");
		for (int i = 0; i < 7; i++) begin
			convert(chs[i], prevs[i]);
		end
		// an aborted frame must leave the stored result untouched
		abort_xfer();
		convert(4'h3, 8'ha5);
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge clock);
		mismatches++;
		complete_run();
	end
endmodule : test_serial_adc_control
`default_nettype wire
